// File: common/fbs_regs.svh
/*
  Offsets, field positions, table constants and timing figures of the bring-up sequencer.
  Assumes it is included by its bare name from the package only; the design uses its macros without including it.
*/
`ifndef FBS_REGS_SVH
`define FBS_REGS_SVH

// APB register offsets of the sequencer
`define FBS_OFF_CTRL      8'h00
`define FBS_OFF_STATUS    8'h04
`define FBS_OFF_IRQ_STAT  8'h08
`define FBS_OFF_IRQ_MASK  8'h0c
`define FBS_OFF_DELAY     8'h10

// Field positions
`define FBS_CTRL_START    0
`define FBS_ST_BUSY       0
`define FBS_ST_DONE       1
`define FBS_ST_ERR        2
`define FBS_ST_LIVE       3
`define FBS_ST_STEP_LSB   8
`define FBS_IRQ_DONE      0
`define FBS_IRQ_ERR       1

// Expander bus address and register addresses
`define FBS_EXP_I2C_ADDR  7'h20
`define FBS_EXP_OUT0      8'h02
`define FBS_EXP_OUT1      8'h03
`define FBS_EXP_OUT2      8'h04
`define FBS_EXP_DIR0      8'h06
`define FBS_EXP_DIR1      8'h07
`define FBS_EXP_DIR2      8'h08

// Module-side FPGA registers reached over SPI, and the values written to them
`define FBS_MOD_IO_RST    8'h00
`define FBS_MOD_FIFO_RST  8'h01
`define FBS_MOD_SRC_A     8'h02
`define FBS_MOD_SRC_B     8'h03
`define FBS_MOD_RST_VAL   8'h01
`define FBS_SRC_ADC       8'h00
`define FBS_SRC_TRAIN     8'h01
`define FBS_SRC_RAMP      8'h02

// Step indices of the sequence table
`define FBS_STEP_LAST_I2C  6'd7
`define FBS_STEP_PLL_FIRST 6'd8
`define FBS_STEP_PLL_NEXT  6'd10
`define FBS_STEP_ADC_LAST  6'd29
`define FBS_STEP_TRAIN_RST 6'd43

// Timing
`define FBS_CLK_NS        100
`define FBS_PLL_WAIT_NS   1000000
`define FBS_PLL_WAIT_CYC  ((`FBS_PLL_WAIT_NS + `FBS_CLK_NS - 1) / `FBS_CLK_NS)

`endif

// File: common/fbs_pkg.sv
/*
  Types of the bring-up sequencer: step kinds, target devices, states and the state record.
  Assumes the constants header is on the include path.
*/
package fbs_pkg;
  `include "fbs_regs.svh"

  typedef enum logic [2:0] {K_I2C, K_SPI, K_WAIT, K_DRST, K_DINC, K_TRAIN, K_RAMP, K_END}
    fbs_kind_type;
  typedef enum logic [1:0] {DEV_PLL, DEV_ADC, DEV_DAC, DEV_MOD} fbs_dev_type;
  typedef enum logic [3:0] {S_IDLE, S_FETCH, S_I2C, S_SPI, S_WAIT, S_DINC, S_TRAIN, S_RAMP,
                            S_DONE, S_FAIL} fbs_state_type;

  typedef struct packed {
    fbs_kind_type kind;
    fbs_dev_type  dev;
    logic [7:0]   addr;
    logic [7:0]   data;
  } fbs_step_type;

  typedef struct packed {
    fbs_state_type st;
    logic [5:0]    idx;
    logic [15:0]   cnt;
    logic          i2c_req;
    logic [7:0]    i2c_reg;
    logic [7:0]    i2c_data;
    logic          spi_req;
    fbs_dev_type   spi_dev;
    logic [7:0]    spi_addr;
    logic [7:0]    spi_data;
    logic          dly_rst;
    logic          dly_inc;
    logic          trn_start;
    logic          rmp_start;
    logic          live;
    logic [1:0]    irq_stat;
    logic [1:0]    irq_mask;
    logic [7:0]    dly_start;
    logic [31:0]   prdata;
  } fbs_state_rec_type;
endpackage

// File: src/fbs_sequencer.sv
/*
  Bring-up sequencer for a converter mezzanine: powers it through an I2C expander, loads
  PLL, ADC and DAC over SPI, trains the input lanes and checks a ramp before live data.
  Assumes external I2C and SPI write engines with a request held until a done pulse, a lane
  training engine and a ramp checker, all on pclk; software drives it over APB.
*/
// Notes on behaviour
// - First expander write puts 0x01 on port zero, local reference clock.
// - Then port one gets 0x00, all supplies off, then port two 0x00.
// - Port zero and port one direction registers get 0x00, all outputs.
// - Port two direction gets 0x3F: bits 5..0 inputs, bits 7..6 outputs.
// - Port one gets 0x10 for switching regulators, only then 0x1F for all.
// - PLL is touched only after reference mux and reference supply are set.
// - PLL gets 0x02 at 0x02 first, then at least 1 ms pause.
// - PLL addresses 0x03 to 0x12 follow in ascending order with table data.
// - ADC gets its four writes in order once its clock is valid.
// - DAC gets its nine writes in order for four-times interpolation.
// - Training follows configuration: module I/O, FIFO reset, training pattern both channels.
// - Reset delays, optionally step to start, launch training, confirm success.
// - Both channels go to ramp, ramp is checked, then live converter data.
`timescale 1ns/1ns

module fbs_sequencer
  import fbs_pkg::*;
#(
  parameter int WAIT_CYCLES = `FBS_PLL_WAIT_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             i2c_req,
  output logic      [6:0]  i2c_dev_addr,
  output logic      [7:0]  i2c_reg_addr,
  output logic      [7:0]  i2c_wdata,
  input  wire logic        i2c_done,
  output logic             spi_req,
  output fbs_dev_type      spi_dev,
  output logic      [7:0]  spi_addr,
  output logic      [7:0]  spi_wdata,
  input  wire logic        spi_done,
  output logic             delay_reset,
  output logic             delay_inc,
  output logic             train_start,
  input  wire logic        train_done,
  input  wire logic        train_ok,
  output logic             ramp_check_start,
  input  wire logic        ramp_done,
  input  wire logic        ramp_ok,
  output logic             live_select
);

  ////////////////////////////////////////////////////////////////////////////////////////
  // Sequence table

  function automatic fbs_step_type fbs_step(input logic [5:0] i);
    fbs_step_type s;
    s = '{K_END, DEV_PLL, 8'h00, 8'h00};
    case (i)
      6'd0:  s = '{K_I2C, DEV_PLL, `FBS_EXP_OUT0, 8'h01};
      6'd1:  s = '{K_I2C, DEV_PLL, `FBS_EXP_OUT1, 8'h00};
      6'd2:  s = '{K_I2C, DEV_PLL, `FBS_EXP_OUT2, 8'h00};
      6'd3:  s = '{K_I2C, DEV_PLL, `FBS_EXP_DIR0, 8'h00};
      6'd4:  s = '{K_I2C, DEV_PLL, `FBS_EXP_DIR1, 8'h00};
      6'd5:  s = '{K_I2C, DEV_PLL, `FBS_EXP_DIR2, 8'h3f};
      6'd6:  s = '{K_I2C, DEV_PLL, `FBS_EXP_OUT1, 8'h10};
      6'd7:  s = '{K_I2C, DEV_PLL, `FBS_EXP_OUT1, 8'h1f};
      6'd8:  s = '{K_SPI, DEV_PLL, 8'h02, 8'h02};
      6'd9:  s = '{K_WAIT, DEV_PLL, 8'h00, 8'h00};
      6'd10: s = '{K_SPI, DEV_PLL, 8'h03, 8'h38};
      6'd11: s = '{K_SPI, DEV_PLL, 8'h04, 8'hb3};
      6'd12: s = '{K_SPI, DEV_PLL, 8'h05, 8'h04};
      6'd13: s = '{K_SPI, DEV_PLL, 8'h06, 8'h32};
      6'd14: s = '{K_SPI, DEV_PLL, 8'h07, 8'h07};
      6'd15: s = '{K_SPI, DEV_PLL, 8'h08, 8'h20};
      6'd16: s = '{K_SPI, DEV_PLL, 8'h09, 8'h83};
      6'd17: s = '{K_SPI, DEV_PLL, 8'h0a, 8'h00};
      6'd18: s = '{K_SPI, DEV_PLL, 8'h0b, 8'h83};
      6'd19: s = '{K_SPI, DEV_PLL, 8'h0c, 8'h00};
      6'd20: s = '{K_SPI, DEV_PLL, 8'h0d, 8'h81};
      6'd21: s = '{K_SPI, DEV_PLL, 8'h0e, 8'h00};
      6'd22: s = '{K_SPI, DEV_PLL, 8'h0f, 8'h81};
      6'd23: s = '{K_SPI, DEV_PLL, 8'h10, 8'h00};
      6'd24: s = '{K_SPI, DEV_PLL, 8'h11, 8'h82};
      6'd25: s = '{K_SPI, DEV_PLL, 8'h12, 8'h00};
      6'd26: s = '{K_SPI, DEV_ADC, 8'h00, 8'h20};
      6'd27: s = '{K_SPI, DEV_ADC, 8'h20, 8'h01};
      6'd28: s = '{K_SPI, DEV_ADC, 8'h14, 8'h00};
      6'd29: s = '{K_SPI, DEV_ADC, 8'hff, 8'h01};
      6'd30: s = '{K_SPI, DEV_DAC, 8'h00, 8'h3a};
      6'd31: s = '{K_SPI, DEV_DAC, 8'h20, 8'h01};
      6'd32: s = '{K_SPI, DEV_DAC, 8'h5e, 8'h00};
      6'd33: s = '{K_SPI, DEV_DAC, 8'h5f, 8'h60};
      6'd34: s = '{K_SPI, DEV_DAC, 8'h0a, 8'h00};
      6'd35: s = '{K_SPI, DEV_DAC, 8'h28, 8'h02};
      6'd36: s = '{K_SPI, DEV_DAC, 8'h26, 8'h80};
      6'd37: s = '{K_SPI, DEV_DAC, 8'h25, 8'h01};
      6'd38: s = '{K_SPI, DEV_DAC, 8'h01, 8'h00};
      6'd39: s = '{K_SPI, DEV_MOD, `FBS_MOD_IO_RST, `FBS_MOD_RST_VAL};
      6'd40: s = '{K_SPI, DEV_MOD, `FBS_MOD_FIFO_RST, `FBS_MOD_RST_VAL};
      6'd41: s = '{K_SPI, DEV_MOD, `FBS_MOD_SRC_A, `FBS_SRC_TRAIN};
      6'd42: s = '{K_SPI, DEV_MOD, `FBS_MOD_SRC_B, `FBS_SRC_TRAIN};
      6'd43: s = '{K_DRST, DEV_PLL, 8'h00, 8'h00};
      6'd44: s = '{K_DINC, DEV_PLL, 8'h00, 8'h00};
      6'd45: s = '{K_TRAIN, DEV_PLL, 8'h00, 8'h00};
      6'd46: s = '{K_SPI, DEV_MOD, `FBS_MOD_SRC_A, `FBS_SRC_RAMP};
      6'd47: s = '{K_SPI, DEV_MOD, `FBS_MOD_SRC_B, `FBS_SRC_RAMP};
      6'd48: s = '{K_RAMP, DEV_PLL, 8'h00, 8'h00};
      6'd49: s = '{K_SPI, DEV_MOD, `FBS_MOD_SRC_A, `FBS_SRC_ADC};
      6'd50: s = '{K_SPI, DEV_MOD, `FBS_MOD_SRC_B, `FBS_SRC_ADC};
      default: s = '{K_END, DEV_PLL, 8'h00, 8'h00};
    endcase
    return s;
  endfunction

  function automatic logic fbs_running(input fbs_state_type st);
    return (st != S_IDLE) && (st != S_DONE) && (st != S_FAIL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////
  // State

  fbs_state_rec_type r_reg;
  fbs_state_rec_type r_next;
  fbs_step_type      step;
  logic              acc_wr;
  logic              mapped;
  logic [1:0]        ev;

  assign step   = fbs_step(r_reg.idx);
  assign acc_wr = psel && penable && pwrite;
  assign mapped = (paddr == `FBS_OFF_CTRL) || (paddr == `FBS_OFF_STATUS) ||
                  (paddr == `FBS_OFF_IRQ_STAT) || (paddr == `FBS_OFF_IRQ_MASK) ||
                  (paddr == `FBS_OFF_DELAY);

  always_comb begin
    r_next = r_reg;
    ev = 2'b00;
    r_next.dly_rst = 1'b0;
    r_next.dly_inc = 1'b0;
    r_next.trn_start = 1'b0;
    r_next.rmp_start = 1'b0;
    case (r_reg.st)
      S_FETCH: begin
        case (step.kind)
          K_I2C: begin
            r_next.i2c_req = 1'b1;
            r_next.i2c_reg = step.addr;
            r_next.i2c_data = step.data;
            r_next.st = S_I2C;
          end
          K_SPI: begin
            r_next.spi_req = 1'b1;
            r_next.spi_dev = step.dev;
            r_next.spi_addr = step.addr;
            r_next.spi_data = step.data;
            r_next.st = S_SPI;
          end
          K_WAIT: begin
            r_next.cnt = 16'h0000;
            r_next.st = S_WAIT;
          end
          K_DRST: begin
            r_next.dly_rst = 1'b1;
            r_next.idx = r_reg.idx + 6'd1;
          end
          K_DINC: begin
            r_next.cnt = 16'h0000;
            r_next.st = S_DINC;
          end
          K_TRAIN: begin
            r_next.trn_start = 1'b1;
            r_next.st = S_TRAIN;
          end
          K_RAMP: begin
            r_next.rmp_start = 1'b1;
            r_next.st = S_RAMP;
          end
          default: begin
            r_next.live = 1'b1;
            r_next.st = S_DONE;
            ev[`FBS_IRQ_DONE] = 1'b1;
          end
        endcase
      end
      S_I2C: begin
        // Request is held until the engine reports completion
        if (i2c_done) begin
          r_next.i2c_req = 1'b0;
          r_next.idx = r_reg.idx + 6'd1;
          r_next.st = S_FETCH;
        end
      end
      S_SPI: begin
        if (spi_done) begin
          r_next.spi_req = 1'b0;
          r_next.idx = r_reg.idx + 6'd1;
          r_next.st = S_FETCH;
        end
      end
      S_WAIT: begin
        if (r_reg.cnt == 16'(WAIT_CYCLES - 1)) begin
          r_next.idx = r_reg.idx + 6'd1;
          r_next.st = S_FETCH;
        end else begin
          r_next.cnt = r_reg.cnt + 16'h0001;
        end
      end
      S_DINC: begin
        // Zero start count skips stepping altogether
        if (r_reg.cnt[7:0] == r_reg.dly_start) begin
          r_next.idx = r_reg.idx + 6'd1;
          r_next.st = S_FETCH;
        end else begin
          r_next.dly_inc = 1'b1;
          r_next.cnt = r_reg.cnt + 16'h0001;
        end
      end
      S_TRAIN: begin
        if (train_done && train_ok) begin
          r_next.idx = r_reg.idx + 6'd1;
          r_next.st = S_FETCH;
        end else if (train_done) begin
          r_next.st = S_FAIL;
          ev[`FBS_IRQ_ERR] = 1'b1;
        end
      end
      S_RAMP: begin
        if (ramp_done && ramp_ok) begin
          r_next.idx = r_reg.idx + 6'd1;
          r_next.st = S_FETCH;
        end else if (ramp_done) begin
          r_next.st = S_FAIL;
          ev[`FBS_IRQ_ERR] = 1'b1;
        end
      end
      default: begin
      end
    endcase

    // Register bus; read data is caught in the setup cycle so no wait state is needed
    if (psel && !penable) begin
      case (paddr)
        `FBS_OFF_STATUS: begin
          r_next.prdata = 32'h0000_0000;
          r_next.prdata[`FBS_ST_BUSY] = fbs_running(r_reg.st);
          r_next.prdata[`FBS_ST_DONE] = (r_reg.st == S_DONE);
          r_next.prdata[`FBS_ST_ERR] = (r_reg.st == S_FAIL);
          r_next.prdata[`FBS_ST_LIVE] = r_reg.live;
          r_next.prdata[`FBS_ST_STEP_LSB +: 6] = r_reg.idx;
        end
        `FBS_OFF_IRQ_STAT: r_next.prdata = {30'h0, r_reg.irq_stat};
        `FBS_OFF_IRQ_MASK: r_next.prdata = {30'h0, r_reg.irq_mask};
        `FBS_OFF_DELAY:    r_next.prdata = {24'h0, r_reg.dly_start};
        default:           r_next.prdata = 32'h0000_0000;
      endcase
    end
    if (acc_wr) begin
      case (paddr)
        `FBS_OFF_CTRL: begin
          // Start while running is ignored
          if (pwdata[`FBS_CTRL_START] && !fbs_running(r_reg.st)) begin
            r_next.idx = 6'd0;
            r_next.live = 1'b0;
            r_next.st = S_FETCH;
          end
        end
        `FBS_OFF_IRQ_STAT: r_next.irq_stat = r_reg.irq_stat & ~pwdata[1:0];
        `FBS_OFF_IRQ_MASK: r_next.irq_mask = pwdata[1:0];
        `FBS_OFF_DELAY:    r_next.dly_start = pwdata[7:0];
        default: begin
        end
      endcase
    end
    // An event in the clearing cycle survives
    r_next.irq_stat = r_next.irq_stat | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata           = r_reg.prdata;
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && !mapped;
  assign irq              = |(r_reg.irq_stat & r_reg.irq_mask);
  assign i2c_req          = r_reg.i2c_req;
  assign i2c_dev_addr     = `FBS_EXP_I2C_ADDR;
  assign i2c_reg_addr     = r_reg.i2c_reg;
  assign i2c_wdata        = r_reg.i2c_data;
  assign spi_req          = r_reg.spi_req;
  assign spi_dev          = r_reg.spi_dev;
  assign spi_addr         = r_reg.spi_addr;
  assign spi_wdata        = r_reg.spi_data;
  assign delay_reset      = r_reg.dly_rst;
  assign delay_inc        = r_reg.dly_inc;
  assign train_start      = r_reg.trn_start;
  assign ramp_check_start = r_reg.rmp_start;
  assign live_select      = r_reg.live;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [15:0] gap_reg;
  logic        ramp_pass_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= 16'h0000;
      ramp_pass_reg <= 1'b0;
    end else begin
      gap_reg <= spi_done ? 16'h0000 : (&gap_reg ? gap_reg : gap_reg + 16'h0001);
      ramp_pass_reg <= (r_reg.st == S_RAMP && ramp_done && ramp_ok) ||
                       (ramp_pass_reg && !(r_reg.st == S_FETCH && r_reg.idx == 6'd0));
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_i2c_table: assert property (i2c_req |-> step.kind == K_I2C && i2c_reg_addr == step.addr
    && i2c_wdata == step.data) else $error("expander write off table");
  a_exp_order: assert property ($rose(i2c_req) && i2c_wdata == 8'h1f |->
    r_reg.idx == `FBS_STEP_LAST_I2C) else $error("all supplies enabled early");
  a_pll_after_pwr: assert property (spi_req |-> r_reg.idx > `FBS_STEP_LAST_I2C)
    else $error("SPI before power up");
  a_pll_pause: assert property ($rose(spi_req) && r_reg.idx == `FBS_STEP_PLL_NEXT |->
    gap_reg >= 16'(WAIT_CYCLES)) else $error("PLL pause too short");
  a_spi_table: assert property (spi_req |-> step.kind == K_SPI && spi_dev == step.dev &&
    spi_addr == step.addr && spi_wdata == step.data) else $error("SPI off table");
  a_one_at_time: assert property (!(i2c_req && spi_req))
    else $error("expander and SPI requests overlap");
  a_spi_held: assert property (spi_req && !spi_done |=> spi_req && $stable(spi_addr))
    else $error("serial request dropped");
  a_train_late: assert property (train_start |-> r_reg.idx > `FBS_STEP_ADC_LAST)
    else $error("training before configuration");
  a_train_fail: assert property (r_reg.st == S_TRAIN && train_done && !train_ok |=>
    r_reg.st == S_FAIL && r_reg.irq_stat[`FBS_IRQ_ERR])
    else $error("training fail not flagged");
  a_live_after_ramp: assert property ($rose(live_select) |-> ramp_pass_reg)
    else $error("live data without ramp pass");
  a_fail_no_live: assert property (r_reg.st == S_FAIL |-> !live_select ##1 !live_select)
    else $error("live data after failure");

  c_full_run: cover property ($rose(live_select));
  c_pll_wait: cover property (r_reg.st == S_WAIT ##1 r_reg.st == S_FETCH);
  c_train_fail: cover property (r_reg.st == S_TRAIN ##1 r_reg.st == S_FAIL);
  c_ramp_fail: cover property (r_reg.st == S_RAMP ##1 r_reg.st == S_FAIL);

endmodule

// File: test/fbs_partner.sv
/*
  Far-side model of the sequencer: expander, PLL, ADC, DAC, module FPGA, lane training engine
  and ramp checker, each answering after a latency that the bench sets.
  Assumes requests held until done, and start pulses of one cycle, all on pclk.
*/
`timescale 1ns/1ns

module fbs_resp (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       trig,
  input  wire logic [3:0] lat,
  output logic            done
);
  logic       armed;
  logic       run;
  logic [3:0] cnt;
  // Re-arms only once the request is gone, so a held request is answered once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b1;
      run   <= 1'b0;
      cnt   <= 4'h0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (trig && armed && !run) begin
        run   <= 1'b1;
        armed <= 1'b0;
        cnt   <= 4'h0;
      end else if (run) begin
        if (cnt >= lat) begin
          done <= 1'b1;
          run  <= 1'b0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else if (!trig) begin
        armed <= 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////////////////
module fbs_partner
  import fbs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        i2c_req,
  input  wire logic [7:0]  i2c_reg_addr,
  input  wire logic [7:0]  i2c_wdata,
  input  wire logic        spi_req,
  input  fbs_dev_type      spi_dev,
  input  wire logic [7:0]  spi_addr,
  input  wire logic        train_start,
  input  wire logic        ramp_check_start,
  input  wire logic [15:0] lat,
  input  wire logic        train_good,
  input  wire logic        ramp_good,
  output logic             i2c_done,
  output logic             spi_done,
  output logic             train_done,
  output logic             train_ok,
  output logic             ramp_done,
  output logic             ramp_ok,
  output logic      [7:0]  supply_en,
  output logic             clk_valid
);
  fbs_resp i_i2c (.pclk, .presetn, .trig(i2c_req), .lat(lat[3:0]), .done(i2c_done));
  fbs_resp i_spi (.pclk, .presetn, .trig(spi_req), .lat(lat[7:4]), .done(spi_done));
  fbs_resp i_trn (.pclk, .presetn, .trig(train_start), .lat(lat[11:8]), .done(train_done));
  fbs_resp i_rmp (.pclk, .presetn, .trig(ramp_check_start), .lat(lat[15:12]), .done(ramp_done));

  // Result is only meaningful with its done pulse; shows the inverse otherwise
  assign train_ok = train_done ? train_good : ~train_good;
  assign ramp_ok  = ramp_done ? ramp_good : ~ramp_good;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_en <= 8'h00;
      clk_valid <= 1'b0;
    end else begin
      if (i2c_req && i2c_done && i2c_reg_addr == 8'h03) begin
        supply_en <= i2c_wdata;
        // Supplies off stop the reference, so the clock is no longer valid
        if (i2c_wdata == 8'h00) clk_valid <= 1'b0;
      end
      if (spi_req && spi_done && spi_dev == DEV_PLL && spi_addr == 8'h12) begin
        clk_valid <= 1'b1;
      end
    end
  end
endmodule

// File: test/fbs_sequencer_tb_top.sv
/*
  Self-checking bench of the bring-up sequencer: APB master, far-side model, handshake monitor.
  Assumes WAIT_CYCLES is a parameter; APB wait states are allowed, as the access phase holds until pready.
*/
`timescale 1ns/1ns

module fbs_sequencer_tb_top
  import fbs_pkg::*;
;
  localparam int WAITC = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, dly;
  logic [31:0] pwdata = 32'h0, prdata, rd, x = 32'd97;
  logic pready, pslverr, irq, i2c_req, i2c_done, spi_req, spi_done, apb_err, prev_spi, ok;
  logic delay_reset, delay_inc, train_start, train_done, train_ok, ramp_check_start;
  logic ramp_done, ramp_ok, live_select, clk_valid, train_good = 1'b1, ramp_good = 1'b1;
  logic [6:0] i2c_dev_addr;
  logic [7:0] i2c_reg_addr, i2c_wdata, spi_addr, spi_wdata, supply_en;
  logic [1:0] mask;
  logic [15:0] lat = 16'h0000;
  fbs_dev_type spi_dev;
  logic [15:0] i2c_tab [8] = '{16'h0201, 16'h0300, 16'h0400, 16'h0600, 16'h0700, 16'h083f,
                               16'h0310, 16'h031f};
  logic [15:0] spi_tab [38] = '{16'h0202, 16'h0338, 16'h04b3, 16'h0504, 16'h0632, 16'h0707,
    16'h0820, 16'h0983, 16'h0a00, 16'h0b83, 16'h0c00, 16'h0d81, 16'h0e00, 16'h0f81, 16'h1000,
    16'h1182, 16'h1200, 16'h0020, 16'h2001, 16'h1400, 16'hff01, 16'h003a, 16'h2001, 16'h5e00,
    16'h5f60, 16'h0a00, 16'h2802, 16'h2680, 16'h2501, 16'h0100, 16'h0001, 16'h0101, 16'h0201,
    16'h0301, 16'h0202, 16'h0302, 16'h0200, 16'h0300};
  logic [15:0] i2c_log [$];
  logic [17:0] spi_log [$];
  int n_mismatch = 0, cmp_count = 0, cyc = 0, n_inc, n_ovl = 0, n_early_adc = 0, n;
  int i2c_at_spi, spi_at_trn, gap, t_pll;

  fbs_sequencer #(.WAIT_CYCLES(WAITC)) i_fbs_sequencer (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .i2c_req, .i2c_dev_addr,
    .i2c_reg_addr, .i2c_wdata, .i2c_done, .spi_req, .spi_dev, .spi_addr, .spi_wdata,
    .spi_done, .delay_reset, .delay_inc, .train_start, .train_done, .train_ok,
    .ramp_check_start, .ramp_done, .ramp_ok, .live_select);
  fbs_partner i_fbs_partner (.pclk, .presetn, .i2c_req, .i2c_reg_addr, .i2c_wdata, .spi_req,
    .spi_dev, .spi_addr, .train_start, .ramp_check_start, .lat, .train_good, .ramp_good,
    .i2c_done, .spi_done, .train_done, .train_ok, .ramp_done, .ramp_ok, .supply_en,
    .clk_valid);

  always #50 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  function automatic logic [17:0] spi_exp(int i);
    fbs_dev_type d;
    d = (i < 17) ? DEV_PLL : (i < 21) ? DEV_ADC : (i < 30) ? DEV_DAC : DEV_MOD;
    return {d, spi_tab[i]};
  endfunction

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Zero-wait slave is not assumed: the access phase holds until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    apb_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Watchdog well above four full bring-ups
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end

  // Sampled mid-cycle, where every registered output and done pulse has settled
  always @(negedge pclk) begin
    if (i2c_req && i2c_done) i2c_log.push_back({i2c_reg_addr, i2c_wdata});
    if (spi_req && spi_done) begin
      if (spi_log.size() == 0) begin
        i2c_at_spi = i2c_log.size();
        t_pll = cyc;
      end
      if (spi_dev == DEV_ADC && !clk_valid) n_early_adc++;
      spi_log.push_back({spi_dev, spi_addr, spi_wdata});
    end
    if (spi_req && !prev_spi && spi_log.size() == 1) gap = cyc - t_pll;
    prev_spi = spi_req;
    if (i2c_req && spi_req) n_ovl++;
    if (delay_reset) n_inc = 0;
    if (delay_inc) n_inc++;
    if (train_start) spi_at_trn = spi_log.size();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(live_select, 1'b0);
    check(supply_en, 8'h00);
    check(i2c_dev_addr, 7'h20);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check(apb_err, 1'b1);
    check(rd, 32'h0);
    for (int r = 0; r < 4; r++) begin
      lat <= 16'(rnd());
      train_good <= (r != 1);
      ramp_good <= (r != 2);
      dly = (r == 0) ? 8'h00 : (r == 3) ? 8'hff : 8'(rnd() & 32'h7);
      mask = 2'(rnd());
      apb(1'b1, 8'h10, {24'h0, dly});
      apb(1'b1, 8'h0c, {30'h0, mask});
      apb(1'b1, 8'h08, 32'h3);
      i2c_log.delete();
      spi_log.delete();
      n_inc = -1000;
      spi_at_trn = -1;
      apb(1'b1, 8'h00, 32'h1);
      // A second start in mid-run must not restart the sequence
      if (r == 3) apb(1'b1, 8'h00, 32'h1);
      do apb(1'b0, 8'h04, 32'h0); while (rd[0] === 1'b1);
      ok = train_good && ramp_good;
      n = !train_good ? 34 : !ramp_good ? 36 : 38;
      check(rd[3:0], {ok, !ok, ok, 1'b0});
      check(live_select, ok);
      check(supply_en, 8'h1f);
      check(i2c_log.size(), 8);
      foreach (i2c_log[i]) check(i2c_log[i], i2c_tab[i]);
      check(spi_log.size(), n);
      foreach (spi_log[i]) check(spi_log[i], spi_exp(i));
      check(i2c_at_spi, 8);
      check(gap >= WAITC + 2, 1'b1);
      check(spi_at_trn, 34);
      check(n_inc, dly);
      check(n_early_adc, 32'h0);
      check(n_ovl, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      check(rd, {30'h0, !ok, ok});
      check(irq, |({!ok, ok} & mask));
      apb(1'b1, 8'h08, 32'h3);
      @(negedge pclk);
      check(irq, 1'b0);
    end
    // Reset in mid-run must drop every request and the sequence itself
    apb(1'b1, 8'h00, 32'h1);
    repeat (40) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({i2c_req, spi_req, live_select}, 3'b000);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0);
    test_done();
  end
endmodule
